// file: common/thread_regs_pkg.sv
// Package for the per-thread halt, context, scheduling and options registers.
// Assumes a coprocessor-move style access: register number, select, thread.
package thread_regs_pkg;

    // Coprocessor register numbers and selects.
    localparam logic [4:0] REG_NUM_THREAD = 5'h02;
    localparam logic [4:0] REG_NUM_OPT = 5'h03;
    localparam logic [2:0] SEL_HALT = 3'h4;
    localparam logic [2:0] SEL_CONTEXT = 3'h5;
    localparam logic [2:0] SEL_HINT = 3'h6;
    localparam logic [2:0] SEL_FEEDBACK = 3'h7;
    localparam logic [2:0] SEL_OPTIONS = 3'h7;

    // Field positions.
    localparam int HALT_BIT = 0;
    localparam int IWX_LSB = 8;
    localparam int DWX_LSB = 0;
    localparam int WAY_MASK_W = 8;

    // Reset values.
    localparam logic HALT_RESET_THREAD0 = 1'b0;
    localparam logic HALT_RESET_OTHERS = 1'b1;
    localparam logic [31:0] WORD_RESET = 32'h00000000;

    // Coprocessor move request.
    typedef struct packed {
        logic       write;
        logic       read;
        logic [4:0] regNum;
        logic [2:0] sel;
        logic [31:0] wdata;
    } cop_req_s;

    // Per-thread blocking cause reported by the pipeline.
    typedef enum logic [2:0] {
        BLK_NONE = 3'b001,
        BLK_GATING = 3'b010,
        BLK_WAIT = 3'b100
    } block_e;

    // Halt sequencing states for one thread.
    typedef enum logic [2:0] {
        HS_RUN = 3'b001,
        HS_DRAIN = 3'b010,
        HS_HALTED = 3'b100
    } halt_state_e;

endpackage

// file: core/thread_halt_schedule_regs.sv
// Per-thread halt, context, scheduling hint, feedback and options registers.
// Assumes a coprocessor move port on the core clock, and a pipeline that
// reports fetch/issue state per thread and honours stop and flush outputs.
//
// Overview of operation
// - Halt bit 0 read/write; set stops scheduling; resets 0 thread0, else 1.
// - Halt bits 31:1 reserved; written zero by software, read as zero.
// - Setting halt on an activated thread stops fetch and captures next unissued address as restart.
// - Halt aborts pending gating-storage access; restart points at it.
// - Halt during wait or relinquish settles thread in stable restart state.
// - Run-state still reports blocked condition and cause after halt.
// - Clearing halt makes thread schedulable, resuming from restart address.
// - Halted thread never chosen for allocation by spawn instruction, except in its first halted cycle if it was not activated.
// - Halt by register write on an activated thread discards fetched but unissued instructions.
// - Halt may lag; long-latency work finishes before barrier completes.
// - Context register is plain software storage with no side effects.
// - Scheduling hint exists per thread and is passed to the scheduler.
// - Hint value zero means default well-behaved scheduling.
// - Thread hints only divide bandwidth granted to the virtual cpu.
// - Feedback register counts retired instructions, cleared by software.
// - Options: instruction mask 15:8, data mask 7:0, bits 31:16 zero.
// - Instruction way n never allocated for thread when its bit set.
`timescale 1ns/1ns
module thread_halt_schedule_regs
    import thread_regs_pkg::*;
#(
    parameter int NUM_THREADS = 4,
    parameter int ADDR_W = 32
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Coprocessor move port.
    input wire cop_req_s copReq,
    input wire logic [$clog2(NUM_THREADS)-1:0] targetThread,
    output logic [31:0] readData,
    output logic readValid,
    // Pipeline state per thread.
    input wire logic [NUM_THREADS-1:0] activated,
    input wire logic [NUM_THREADS*ADDR_W-1:0] nextIssueAddr,
    input wire logic [NUM_THREADS*ADDR_W-1:0] blockedAccessAddr,
    input wire logic [NUM_THREADS-1:0] blockedInDelaySlot,
    input wire logic [NUM_THREADS*3-1:0] blockCause,
    input wire logic [NUM_THREADS-1:0] longOpsPending,
    input wire logic [NUM_THREADS-1:0] retired,
    // Controls to scheduler, fetch and cache controller.
    output logic [NUM_THREADS-1:0] schedulable,
    output logic [NUM_THREADS-1:0] spawnEligible,
    output logic [NUM_THREADS-1:0] stopFetch,
    output logic [NUM_THREADS-1:0] flushUnissued,
    output logic [NUM_THREADS-1:0] abortBlocked,
    output logic [NUM_THREADS-1:0] haltSettled,
    output logic [NUM_THREADS-1:0] restartWrite,
    output logic [NUM_THREADS*ADDR_W-1:0] restartAddr,
    output logic [NUM_THREADS-1:0] restartDelaySlot,
    output logic [NUM_THREADS*3-1:0] runStateCause,
    output logic [NUM_THREADS*32-1:0] scheduleHint,
    output logic [NUM_THREADS*WAY_MASK_W-1:0] instrWayExclude,
    output logic [NUM_THREADS*WAY_MASK_W-1:0] dataWayExclude
);

    // Restart words and the coprocessor data path assume 32-bit addresses.
    if (NUM_THREADS < 2 || ADDR_W != 32) begin : gBadParams
        $error("thread_halt_schedule_regs: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage and decode.

    logic [NUM_THREADS-1:0] haltFlag;
    logic [31:0] contextReg [NUM_THREADS];
    logic [31:0] hintReg [NUM_THREADS];
    logic [31:0] feedbackReg [NUM_THREADS];
    logic [2*WAY_MASK_W-1:0] optionsReg [NUM_THREADS];
    halt_state_e haltState [NUM_THREADS];

    function automatic logic hits(input cop_req_s r, input logic [4:0] n,
                                  input logic [2:0] s);
        return r.regNum == n && r.sel == s;
    endfunction

    logic wrHalt, wrContext, wrHint, wrFeedback, wrOptions;
    assign wrHalt = copReq.write && hits(copReq, REG_NUM_THREAD, SEL_HALT);
    assign wrContext = copReq.write
        && hits(copReq, REG_NUM_THREAD, SEL_CONTEXT);
    assign wrHint = copReq.write && hits(copReq, REG_NUM_THREAD, SEL_HINT);
    assign wrFeedback = copReq.write
        && hits(copReq, REG_NUM_THREAD, SEL_FEEDBACK);
    assign wrOptions = copReq.write && hits(copReq, REG_NUM_OPT, SEL_OPTIONS);

    ////////////////////////////////////////////////////////////////////////
    // Halt flag and plain registers.

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            haltFlag <= {NUM_THREADS{HALT_RESET_OTHERS}};
            haltFlag[0] <= HALT_RESET_THREAD0;
        end else if (wrHalt) begin
            haltFlag[targetThread] <= copReq.wdata[HALT_BIT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_THREADS; i++) begin
                contextReg[i] <= WORD_RESET;
            end
        end else if (wrContext) begin
            contextReg[targetThread] <= copReq.wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_THREADS; i++) begin
                hintReg[i] <= WORD_RESET;
            end
        end else if (wrHint) begin
            hintReg[targetThread] <= copReq.wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_THREADS; i++) begin
                feedbackReg[i] <= WORD_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_THREADS; i++) begin
                // A write that meets a retire keeps that retire in the count.
                if (wrFeedback && targetThread == i) begin
                    feedbackReg[i] <= copReq.wdata + {31'h0, retired[i]};
                end else if (retired[i]) begin
                    feedbackReg[i] <= feedbackReg[i] + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_THREADS; i++) begin
                optionsReg[i] <= '0;
            end
        end else if (wrOptions) begin
            optionsReg[targetThread] <= copReq.wdata[2*WAY_MASK_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port.
    // Unmapped locations still answer, with zero data.

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readData <= WORD_RESET;
            readValid <= 1'b0;
        end else begin
            readValid <= copReq.read;
            readData <= WORD_RESET;
            if (copReq.read) begin
                if (hits(copReq, REG_NUM_THREAD, SEL_HALT)) begin
                    readData <= {31'h0, haltFlag[targetThread]};
                end else if (hits(copReq, REG_NUM_THREAD, SEL_CONTEXT)) begin
                    readData <= contextReg[targetThread];
                end else if (hits(copReq, REG_NUM_THREAD, SEL_HINT)) begin
                    readData <= hintReg[targetThread];
                end else if (hits(copReq, REG_NUM_THREAD, SEL_FEEDBACK)) begin
                    readData <= feedbackReg[targetThread];
                end else if (hits(copReq, REG_NUM_OPT, SEL_OPTIONS)) begin
                    readData <= {16'h0, optionsReg[targetThread]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Halt sequencing per thread.

    for (genvar t = 0; t < NUM_THREADS; t++) begin : gThread
        logic haltReq;
        logic isGating;
        logic isWait;
        assign haltReq = wrHalt && targetThread == t
            && copReq.wdata[HALT_BIT] && activated[t];
        assign isGating = blockCause[t*3 +: 3] == BLK_GATING;
        assign isWait = blockCause[t*3 +: 3] == BLK_WAIT;

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                // Thread 0 leaves reset running; the others wait halted.
                haltState[t] <= (t == 0) ? HS_RUN : HS_HALTED;
            end else begin
                case (haltState[t])
                    HS_RUN: begin
                        if (haltReq) begin
                            haltState[t] <= HS_DRAIN;
                        end
                    end
                    HS_DRAIN: begin
                        if (!longOpsPending[t]) begin
                            haltState[t] <= HS_HALTED;
                        end
                    end
                    HS_HALTED: begin
                        if (!haltFlag[t]) begin
                            haltState[t] <= HS_RUN;
                        end
                    end
                    default: haltState[t] <= HS_HALTED;
                endcase
            end
        end

        // Pulses and captured restart state on the halting write.
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                flushUnissued[t] <= 1'b0;
                abortBlocked[t] <= 1'b0;
                restartWrite[t] <= 1'b0;
                restartAddr[t*ADDR_W +: ADDR_W] <= '0;
                restartDelaySlot[t] <= 1'b0;
                runStateCause[t*3 +: 3] <= BLK_NONE;
            end else begin
                flushUnissued[t] <= haltReq && haltState[t] == HS_RUN;
                abortBlocked[t] <= haltReq && haltState[t] == HS_RUN
                    && isGating;
                restartWrite[t] <= haltReq && haltState[t] == HS_RUN;
                if (haltReq && haltState[t] == HS_RUN) begin
                    restartAddr[t*ADDR_W +: ADDR_W] <= isGating
                        ? blockedAccessAddr[t*ADDR_W +: ADDR_W]
                        : nextIssueAddr[t*ADDR_W +: ADDR_W];
                    restartDelaySlot[t] <= isGating && blockedInDelaySlot[t];
                    runStateCause[t*3 +: 3] <= blockCause[t*3 +: 3];
                end else if (haltState[t] == HS_RUN) begin
                    runStateCause[t*3 +: 3] <= blockCause[t*3 +: 3];
                end
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                stopFetch[t] <= (t != 0);
                haltSettled[t] <= (t != 0);
                schedulable[t] <= (t == 0);
                spawnEligible[t] <= (t == 0);
            end else begin
                // A halting write raises stopFetch and drops schedulable and spawnEligible with the pulses.
                // stop fetch
                stopFetch[t] <= haltReq || haltState[t] != HS_RUN
                    && haltFlag[t];
                haltSettled[t] <= haltState[t] == HS_HALTED
                    || haltState[t] == HS_DRAIN && isWait
                    && !longOpsPending[t];
                schedulable[t] <= !haltFlag[t] && !haltReq
                    && haltState[t] != HS_DRAIN;
                spawnEligible[t] <= !haltFlag[t] && !haltReq;
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                scheduleHint[t*32 +: 32] <= WORD_RESET;
            end else begin
                scheduleHint[t*32 +: 32] <= hintReg[t];
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                instrWayExclude[t*WAY_MASK_W +: WAY_MASK_W] <= '0;
                dataWayExclude[t*WAY_MASK_W +: WAY_MASK_W] <= '0;
            end else begin
                instrWayExclude[t*WAY_MASK_W +: WAY_MASK_W] <=
                    optionsReg[t][IWX_LSB +: WAY_MASK_W];
                dataWayExclude[t*WAY_MASK_W +: WAY_MASK_W] <=
                    optionsReg[t][DWX_LSB +: WAY_MASK_W];
            end
        end
    end

endmodule

// file: verif/thread_halt_props.sv
// Checker for the thread halt and schedule register block.
// Bound into every instance of the block; sees only its ports.
`timescale 1ns/1ns
module thread_halt_props
    import thread_regs_pkg::*;
#(
    parameter int NUM_THREADS = 4,
    parameter int ADDR_W = 32
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Register port.
    input wire cop_req_s copReq,
    input wire logic [31:0] readData,
    input wire logic readValid,
    // Pipeline state.
    input wire logic [NUM_THREADS*ADDR_W-1:0] nextIssueAddr,
    input wire logic [NUM_THREADS*ADDR_W-1:0] blockedAccessAddr,
    input wire logic [NUM_THREADS*3-1:0] blockCause,
    input wire logic [NUM_THREADS-1:0] longOpsPending,
    // Controls.
    input wire logic [NUM_THREADS-1:0] schedulable,
    input wire logic [NUM_THREADS-1:0] spawnEligible,
    input wire logic [NUM_THREADS-1:0] stopFetch,
    input wire logic [NUM_THREADS-1:0] flushUnissued,
    input wire logic [NUM_THREADS-1:0] abortBlocked,
    input wire logic [NUM_THREADS-1:0] haltSettled,
    input wire logic [NUM_THREADS-1:0] restartWrite,
    input wire logic [NUM_THREADS*ADDR_W-1:0] restartAddr,
    input wire logic [NUM_THREADS*3-1:0] runStateCause
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence haltRead;
        copReq.read && copReq.regNum == REG_NUM_THREAD &&
            copReq.sel == SEL_HALT;
    endsequence
    AST_READ_ANSWERED: assert property (
        copReq.read |=> readValid) else $error("read not answered");
    AST_HALT_RESERVED_ZERO: assert property (
        haltRead |=> readData[31:1] == '0) else $error("reserved bits set");
    ////////////////////////////////////////////////////////////////////////
    for (genvar t = 0; t < NUM_THREADS; t++) begin : g_thr
        sequence haltTaken;
            flushUnissued[t] && restartWrite[t];
        endsequence
        sequence drained;
            $fell(longOpsPending[t]) && stopFetch[t];
        endsequence
        AST_HALT_STOPS: assert property (
            haltTaken |-> stopFetch[t] && !schedulable[t] && !spawnEligible[t])
            else $error("halt did not stop thread");
        AST_FLUSH_WITH_CAPTURE: assert property (
            flushUnissued[t] |-> restartWrite[t] ##1 !flushUnissued[t])
            else $error("flush without capture");
        AST_ABORT_ONLY_GATING: assert property (
            haltTaken |-> abortBlocked[t] ==
                ($past(blockCause[t*3 +: 3]) == BLK_GATING))
            else $error("abort mismatch");
        AST_RESTART_ADDR: assert property (
            haltTaken |-> restartAddr[t*ADDR_W +: ADDR_W] ==
                ($past(blockCause[t*3 +: 3]) == BLK_GATING ?
                $past(blockedAccessAddr[t*ADDR_W +: ADDR_W]) :
                $past(nextIssueAddr[t*ADDR_W +: ADDR_W])))
            else $error("restart address wrong");
        AST_CAUSE_REPORTED: assert property (
            haltTaken |-> runStateCause[t*3 +: 3] ==
                $past(blockCause[t*3 +: 3]))
            else $error("cause not reported");
        AST_SETTLE_AFTER_DRAIN: assert property (
            drained |-> ##[0:3] haltSettled[t]) else $error("halt not settled");
        AST_SETTLE_NOT_EARLY: assert property (
            $rose(haltSettled[t]) |-> !$past(longOpsPending[t]))
            else $error("settled with work pending");
    end
endmodule

bind thread_halt_schedule_regs thread_halt_props #(
    .NUM_THREADS(NUM_THREADS),
    .ADDR_W(ADDR_W)
) i_thread_halt_props (
    .clock, .rst, .copReq, .readData, .readValid, .nextIssueAddr,
    .blockedAccessAddr, .blockCause, .longOpsPending, .schedulable,
    .spawnEligible, .stopFetch, .flushUnissued, .abortBlocked,
    .haltSettled, .restartWrite, .restartAddr, .runStateCause
);

// file: verif/thread_halt_schedule_regs_tb.sv
// Testbench for the thread halt and schedule register block.
// Drives the coprocessor port at the falling edge; a pipeline model answers.
`timescale 1ns/1ns
module thread_halt_schedule_regs_tb import thread_regs_pkg::*;;
    logic clock, rst, readValid;
    cop_req_s copReq;
    logic [1:0] targetThread;
    logic [31:0] readData;
    logic [3:0] activated, blockedInDelaySlot, longOpsPending, retired;
    logic [3:0] schedulable, spawnEligible, stopFetch, flushUnissued;
    logic [3:0] abortBlocked, haltSettled, restartWrite, restartDelaySlot;
    logic [127:0] nextIssueAddr, blockedAccessAddr, restartAddr, scheduleHint;
    logic [11:0] blockCause, runStateCause;
    logic [31:0] instrWayExclude, dataWayExclude;
    int failures, comparisons, cycles;
    int aborts, flushes;
    thread_halt_schedule_regs i_thread_halt_schedule_regs (.clock, .rst,
        .copReq, .targetThread, .readData, .readValid, .activated,
        .nextIssueAddr, .blockedAccessAddr, .blockedInDelaySlot, .blockCause,
        .longOpsPending, .retired, .schedulable, .spawnEligible, .stopFetch,
        .flushUnissued, .abortBlocked, .haltSettled, .restartWrite,
        .restartAddr, .restartDelaySlot, .runStateCause, .scheduleHint,
        .instrWayExclude, .dataWayExclude);
    thread_pipe_model i_thread_pipe_model (.clock, .rst, .schedulable,
        .stopFetch, .flushUnissued, .nextIssueAddr, .blockedAccessAddr,
        .blockedInDelaySlot, .longOpsPending, .retired);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    always @(negedge clock) begin
        aborts <= aborts + $countones(abortBlocked);
        flushes <= flushes + $countones(flushUnissued);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cop(input logic wr, input logic [4:0] rn,
        input logic [2:0] sl, input logic [1:0] thr, input logic [31:0] d);
        @(negedge clock);
        copReq = '{write: wr, read: !wr, regNum: rn, sel: sl, wdata: d};
        targetThread = thr;
        @(negedge clock);
        copReq.write = 1'b0;
        copReq.read = 1'b0;
    endtask
    task automatic rd(input logic [4:0] rn, input logic [2:0] sl,
        input logic [1:0] thr, input logic [31:0] exp);
        cop(1'b0, rn, sl, thr, 32'h0);
        check(32'(readValid), 32'h1);
        check(readData, exp);
    endtask
    task automatic halt(input logic [1:0] thr, input logic v);
        cop(1'b1, REG_NUM_THREAD, SEL_HALT, thr, 32'(v));
        @(negedge clock);
    endtask
    task automatic settle(input int thr);
        repeat (20) if (haltSettled[thr] !== 1'b1) @(negedge clock);
        check(32'(haltSettled[thr]), 32'h1);
    endtask
    initial begin
        copReq = '0;
        targetThread = 2'h0;
        activated = 4'h7;
        blockCause = {4{BLK_NONE}};
        rst = 1'b1;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        for (int t = 0; t < 4; t++) begin
            rd(REG_NUM_THREAD, SEL_HALT, 2'(t), 32'(t != 0));
            rd(REG_NUM_THREAD, SEL_HINT, 2'(t), 32'h0);
            cop(1'b1, REG_NUM_THREAD, SEL_CONTEXT, 2'(t), 32'hc0de_0000 ^ t);
            cop(1'b1, REG_NUM_THREAD, SEL_HINT, 2'(t), 32'h11 << t);
            cop(1'b1, REG_NUM_OPT, SEL_OPTIONS, 2'(t), 32'hffff_a55a ^ t);
        end
        check(32'(spawnEligible), 32'h1);
        for (int t = 0; t < 4; t++) begin
            rd(REG_NUM_THREAD, SEL_CONTEXT, 2'(t), 32'hc0de_0000 ^ t);
            rd(REG_NUM_THREAD, SEL_HINT, 2'(t), 32'h11 << t);
            check(scheduleHint[t*32 +: 32], 32'h11 << t);
            rd(REG_NUM_OPT, SEL_OPTIONS, 2'(t), 32'h0000_a55a ^ 32'(t));
            check(32'(instrWayExclude[t*8 +: 8]), 32'ha5);
            check(32'(dataWayExclude[t*8 +: 8]), 32'h5a ^ 32'(t));
        end
        cop(1'b1, 5'h05, 3'h0, 2'h0, 32'hffff_ffff);
        rd(5'h05, 3'h0, 2'h0, 32'h0);
        cop(1'b1, REG_NUM_THREAD, SEL_HALT, 2'h3, 32'hffff_fffe);
        rd(REG_NUM_THREAD, SEL_HALT, 2'h3, 32'h0);
        cop(1'b1, REG_NUM_THREAD, SEL_FEEDBACK, 2'h2, 32'h42);
        rd(REG_NUM_THREAD, SEL_FEEDBACK, 2'h2, 32'h42);
        cop(1'b0, REG_NUM_THREAD, SEL_FEEDBACK, 2'h0, 32'h0);
        check(32'(readData != 32'h0), 32'h1);
        halt(2'h0, 1'b1);
        check(32'({stopFetch[0], schedulable[0], spawnEligible[0]}), 4);
        check(flushes, 1);
        check(aborts, 0);
        settle(0);
        halt(2'h0, 1'b0);
        @(negedge clock);
        check(32'({stopFetch[0], schedulable[0]}), 32'h1);
        halt(2'h1, 1'b0);
        blockCause[5:3] = BLK_GATING;
        halt(2'h1, 1'b1);
        check(restartAddr[63:32], 32'h0000_8004);
        check(32'(restartDelaySlot[1]), 32'h1);
        check(32'(runStateCause[5:3]), 32'(BLK_GATING));
        check(aborts, 1);
        check(flushes, 2);
        settle(1);
        halt(2'h2, 1'b0);
        blockCause[8:6] = BLK_WAIT;
        halt(2'h2, 1'b1);
        settle(2);
        check(32'(runStateCause[8:6]), 32'(BLK_WAIT));
        check(aborts, 1);
        check(flushes, 3);
        halt(2'h3, 1'b1);
        check(flushes, 3);
        check(32'({schedulable[3], spawnEligible[3]}), 0);
        final_report();
    end
endmodule

// file: verif/thread_pipe_model.sv
// Behavioural fetch and issue pipeline facing the register block.
// Drives at the falling edge; thread 2 drains at once, others slowly.
`timescale 1ns/1ns
module thread_pipe_model
    import thread_regs_pkg::*;
#(
    parameter int NUM_THREADS = 4,
    parameter int ADDR_W = 32
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Controls from the block.
    input wire logic [NUM_THREADS-1:0] schedulable,
    input wire logic [NUM_THREADS-1:0] stopFetch,
    input wire logic [NUM_THREADS-1:0] flushUnissued,
    // State back to the block.
    output logic [NUM_THREADS*ADDR_W-1:0] nextIssueAddr,
    output logic [NUM_THREADS*ADDR_W-1:0] blockedAccessAddr,
    output logic [NUM_THREADS-1:0] blockedInDelaySlot,
    output logic [NUM_THREADS-1:0] longOpsPending,
    output logic [NUM_THREADS-1:0] retired
);
    int drain [NUM_THREADS];
    always @(negedge clock or posedge rst) begin
        for (int t = 0; t < NUM_THREADS; t++) begin
            if (rst) begin
                nextIssueAddr[t*ADDR_W +: ADDR_W] <= ADDR_W'(32'h1000 + t * 256);
                blockedAccessAddr[t*ADDR_W +: ADDR_W] <=
                    ADDR_W'(32'h8000 + t * 4);
                blockedInDelaySlot[t] <= t[0];
                drain[t] <= 0;
                longOpsPending[t] <= 1'b0;
                retired[t] <= 1'b0;
            end else begin
                if (!stopFetch[t]) begin
                    nextIssueAddr[t*ADDR_W +: ADDR_W] <=
                        nextIssueAddr[t*ADDR_W +: ADDR_W] + ADDR_W'(4);
                end
                if (flushUnissued[t] && t != 2) begin
                    drain[t] <= 3;
                end else if (drain[t] > 0) begin
                    drain[t] <= drain[t] - 1;
                end
                longOpsPending[t] <= flushUnissued[t] && t != 2
                    || drain[t] > 1;
                retired[t] <= schedulable[t] && !stopFetch[t];
            end
        end
    end
endmodule
